//--- rtl/cgr_pkg.sv
// Purpose: constants and carriers for the charge gauge register bank
// Assumes: 8-bit registers, 7-bit register address
// Notes:   shared by the register bank, its property checks, host model and testbench
package cgr_pkg;

  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_PRIMARY  = 7'h01;
  localparam logic [6:0] ADDR_TMPGAUGE = 7'h02;
  localparam logic [6:0] ADDR_CHG_HI   = 7'h03;
  localparam logic [6:0] ADDR_PACK_ID  = 7'h04;
  localparam logic [6:0] ADDR_LEARNED  = 7'h05;
  localparam logic [6:0] ADDR_SEC_FLG  = 7'h06;
  localparam logic [6:0] ADDR_PULLDN   = 7'h07;
  localparam logic [6:0] ADDR_PULLUP   = 7'h08;
  localparam logic [6:0] ADDR_RECHG    = 7'h09;
  localparam logic [6:0] ADDR_CHG_LO   = 7'h17;

  // ----------------------------------------------------------------
  // field positions and values
  // ----------------------------------------------------------------
  localparam int          CMD_WRITE_BIT   = 7;
  localparam int          SEC_FAST_BIT    = 7;
  localparam int          SEC_OVERLOAD_FLAG_BIT    = 0;
  localparam int          PRI_DOUBT_BIT   = 4;
  localparam logic [2:0]  REGIME_LIGHT    = 3'h0;
  localparam logic [2:0]  REGIME_HEAVY    = 3'h1;
  localparam logic [7:0]  RECHG_MAX       = 8'hFF;
  localparam logic [7:0]  RECHG_DOUBT     = 8'h40;
  localparam logic [7:0]  BYTE_ZERO       = 8'h00;
  localparam logic [3:0]  BAND_MAX        = 4'hC;
  localparam logic [3:0]  BAND_ZERO_C     = 4'h4;
  localparam logic [3:0]  BAND_MINUS_10   = 4'h3;
  localparam logic [3:0]  BAND_MINUS_20   = 4'h2;
  localparam logic [3:0]  BAND_PLUS_10    = 4'h5;
  localparam logic [4:0]  SIXTEENTHS_MAX  = 5'h0F;
  localparam logic [15:0] SELF_DISCH_MAX  = 16'h1000;
  // 0.94 threshold as (count*100) > (learned*94)
  localparam logic [7:0]  PCT_FULL        = 8'h64;
  localparam logic [7:0]  PCT_NEAR_FULL   = 8'h5E;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ             = 200_000_000;
  localparam int OVERLOAD_FLAG_RELEASE_MS    = 500;
  localparam int OVERLOAD_FLAG_RELEASE_CYC   = (CLK_HZ / 1000) * OVERLOAD_FLAG_RELEASE_MS;
  localparam int FAST_WINDOW_MS     = 1000;
  localparam int FAST_WINDOW_CYC    = (CLK_HZ / 1000) * FAST_WINDOW_MS;
  localparam int FAST_MIN_COUNTS    = 2;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {CGR_DERATE_FULL, CGR_DERATE_3Q, CGR_DERATE_HALF} cgr_derate_t;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [6:0] addr;
    logic [7:0] data;
  } cgr_req_t;

  typedef struct packed {
    logic charge_tick;
    logic discharge_tick;
    logic valid_charge;
    logic empty_warn;
    logic charge_begin;
    logic sense_below_150;
    logic sense_below_250;
  } cgr_events_t;

endpackage

//--- rtl/cgr_register_bank.sv
// Purpose: register bank and counting logic of a battery charge monitor
// Assumes: analog front end and serial framer deliver synchronous events
// Notes:   pins from outside pass a two-flop synchroniser
`timescale 1ns/1ps

module cgr_register_bank #(
  parameter int OVERLOAD_FLAG_RELEASE_CYCLES = cgr_pkg::OVERLOAD_FLAG_RELEASE_CYC,
  parameter int FAST_WINDOW_CYCLES  = cgr_pkg::FAST_WINDOW_CYC
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 clk_en,
  // host command port
  input  wire cgr_pkg::cgr_req_t    host_req,
  output logic [7:0]                rd_data,
  output logic                      rd_valid,
  // measurement events
  input  wire cgr_pkg::cgr_events_t meas_ev,
  input  wire logic [3:0]           temp_band_code,
  input  wire logic [15:0]          self_disch_count,
  input  wire logic [7:0]           programmed_full_capacity,
  // pins
  input  wire logic                 sixth_program_pin,
  input  wire logic [5:0]           segment_pulldown,
  input  wire logic [5:0]           segment_pullup,
  // status
  output logic                      capacity_doubt_flag,
  output logic                      fast_rate_flag,
  output logic                      edv_sampling_en
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [12:0] pin_meta_reg;
  logic [12:0] pin_sync_reg;
  logic        strap_done_reg;
  logic [1:0]  strap_pipe_reg;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
    end
    else if (clk_en)
    begin
      pin_meta_reg <= {sixth_program_pin, segment_pullup, segment_pulldown};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0]  charge_count_high;
  logic [7:0]  charge_count_low;
  logic [7:0]  pack_identity_reg;
  logic [7:0]  learned_capacity;
  logic [7:0]  recharge_count_reg;
  logic [5:0]  pulldown_bits_reg;
  logic [5:0]  pullup_bits_reg;
  logic [2:0]  discharge_regime_code;
  logic        overload_flag;
  logic        near_full_lock_reg;
  logic        full_start_reg;
  logic        learn_ok_reg;
  logic        learn_update;
  logic        wr_hit;
  logic [15:0] charge_count;
  logic        near_full;

  assign charge_count = {charge_count_high, charge_count_low};
  assign wr_hit = host_req.valid && host_req.write;
  assign near_full = (32'(charge_count_high) * 32'(cgr_pkg::PCT_FULL))
                   > (32'(learned_capacity) * 32'(cgr_pkg::PCT_NEAR_FULL));

  // pin six is strapped once its two-flop sample is valid
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      {strap_done_reg, strap_pipe_reg} <= 3'h0;
    else if (clk_en)
      {strap_done_reg, strap_pipe_reg} <= {strap_pipe_reg, 1'b1};
  end

  // charge count
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      charge_count_high <= cgr_pkg::BYTE_ZERO;
      charge_count_low  <= cgr_pkg::BYTE_ZERO;
    end
    else if (clk_en)
    begin
      if (!strap_done_reg)
      begin
        // count held clear until the synchronised strap is ready
        if (strap_pipe_reg[1] && pin_sync_reg[12])
          charge_count_high <= programmed_full_capacity;
        else
          charge_count_high <= cgr_pkg::BYTE_ZERO;
        charge_count_low <= cgr_pkg::BYTE_ZERO;
      end
      else if (wr_hit && host_req.addr == cgr_pkg::ADDR_CHG_HI)
        charge_count_high <= host_req.data;
      else if (meas_ev.valid_charge)
        charge_count_low <= cgr_pkg::BYTE_ZERO;
      else if (meas_ev.charge_tick && charge_count != 16'hFFFF)
        {charge_count_high, charge_count_low} <= charge_count + 16'h0001;
      else if (meas_ev.discharge_tick && charge_count != 16'h0000)
        {charge_count_high, charge_count_low} <= charge_count - 16'h0001;
    end
  end

  // pack identity: plain storage
  always_ff @(posedge clk)
  begin
    if (clk_en && wr_hit && host_req.addr == cgr_pkg::ADDR_PACK_ID)
      pack_identity_reg <= host_req.data;
  end

  // learned capacity qualification
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      full_start_reg <= 1'b0;
      learn_ok_reg   <= 1'b0;
    end
    else if (clk_en)
    begin
      if (meas_ev.discharge_tick && charge_count_high == learned_capacity)
      begin
        full_start_reg <= 1'b1;
        learn_ok_reg   <= 1'b1;
      end
      else if (meas_ev.valid_charge || self_disch_count >= cgr_pkg::SELF_DISCH_MAX)
        learn_ok_reg <= 1'b0;
      if (learn_update)
        full_start_reg <= 1'b0;
    end
  end

  assign learn_update = meas_ev.empty_warn && edv_sampling_en && learn_ok_reg
                     && full_start_reg && temp_band_code >= cgr_pkg::BAND_ZERO_C;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      learned_capacity <= cgr_pkg::BYTE_ZERO;
    else if (clk_en)
    begin
      if (!strap_done_reg)
        learned_capacity <= programmed_full_capacity;
      else if (wr_hit && host_req.addr == cgr_pkg::ADDR_LEARNED)
        learned_capacity <= host_req.data;
      else if (learn_update)
        learned_capacity <= learned_capacity - charge_count_high;
    end
  end

  // recharge counter and doubt flag
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      recharge_count_reg  <= cgr_pkg::BYTE_ZERO;
      capacity_doubt_flag <= 1'b1;
      near_full_lock_reg  <= 1'b0;
    end
    else if (clk_en)
    begin
      if (learn_update)
      begin
        recharge_count_reg  <= cgr_pkg::BYTE_ZERO;
        capacity_doubt_flag <= 1'b0;
      end
      else if (meas_ev.valid_charge && !near_full_lock_reg
               && recharge_count_reg != cgr_pkg::RECHG_MAX)
      begin
        recharge_count_reg <= recharge_count_reg + 8'h01;
        if (recharge_count_reg + 8'h01 == cgr_pkg::RECHG_DOUBT)
          capacity_doubt_flag <= 1'b1;
      end
      if (meas_ev.valid_charge && near_full)
        near_full_lock_reg <= 1'b1;
      else if (!near_full)
        near_full_lock_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // fast rate flag
  // ----------------------------------------------------------------
  logic [31:0] rate_timer_reg;
  logic [1:0]  rate_count_reg;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fast_rate_flag <= 1'b0;
      rate_timer_reg <= '0;
      rate_count_reg <= '0;
    end
    else if (clk_en)
    begin
      if (meas_ev.charge_begin)
      begin
        fast_rate_flag <= 1'b1;
        rate_timer_reg <= '0;
        rate_count_reg <= '0;
      end
      else if (rate_timer_reg == 32'(FAST_WINDOW_CYCLES - 1))
      begin
        if (rate_count_reg < 2'(cgr_pkg::FAST_MIN_COUNTS))
          fast_rate_flag <= 1'b0;
        rate_timer_reg <= '0;
        rate_count_reg <= '0;
      end
      else
      begin
        rate_timer_reg <= rate_timer_reg + 32'h0000_0001;
        if (meas_ev.charge_tick && rate_count_reg != 2'h3)
          rate_count_reg <= rate_count_reg + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // discharge regime and overload
  // ----------------------------------------------------------------
  logic [31:0] overload_flag_timer_reg;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      discharge_regime_code <= cgr_pkg::REGIME_LIGHT;
    else if (clk_en)
      discharge_regime_code <= meas_ev.sense_below_150 ? cgr_pkg::REGIME_HEAVY
                                                       : cgr_pkg::REGIME_LIGHT;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      overload_flag   <= 1'b0;
      edv_sampling_en <= 1'b1;
      overload_flag_timer_reg  <= '0;
    end
    else if (clk_en)
    begin
      if (meas_ev.sense_below_250)
      begin
        overload_flag   <= 1'b1;
        edv_sampling_en <= 1'b0;
        overload_flag_timer_reg  <= '0;
      end
      else if (overload_flag)
      begin
        if (overload_flag_timer_reg == 32'(OVERLOAD_FLAG_RELEASE_CYCLES - 1))
        begin
          overload_flag   <= 1'b0;
          edv_sampling_en <= 1'b1;
        end
        else
          overload_flag_timer_reg <= overload_flag_timer_reg + 32'h0000_0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // resistor detect
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pulldown_bits_reg <= '0;
      pullup_bits_reg   <= '0;
    end
    else if (clk_en)
    begin
      pulldown_bits_reg <= pin_sync_reg[5:0];
      pullup_bits_reg   <= pin_sync_reg[11:6];
    end
  end

  // ----------------------------------------------------------------
  // temperature band and gauge
  // ----------------------------------------------------------------
  cgr_pkg::cgr_derate_t derate_reg;
  logic [3:0]           band_reg;
  logic [15:0]          full_ref;
  logic [19:0]          scaled;
  logic [4:0]           sixteenths;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      derate_reg <= cgr_pkg::CGR_DERATE_FULL;
      band_reg   <= '0;
    end
    else if (clk_en)
    begin
      band_reg <= (temp_band_code > cgr_pkg::BAND_MAX) ? cgr_pkg::BAND_MAX
                                                       : temp_band_code;
      case (derate_reg)
        cgr_pkg::CGR_DERATE_FULL:
          if (temp_band_code < cgr_pkg::BAND_MINUS_20)
            derate_reg <= cgr_pkg::CGR_DERATE_HALF;
          else if (temp_band_code < cgr_pkg::BAND_ZERO_C)
            derate_reg <= cgr_pkg::CGR_DERATE_3Q;
        cgr_pkg::CGR_DERATE_3Q:
          if (temp_band_code < cgr_pkg::BAND_MINUS_20)
            derate_reg <= cgr_pkg::CGR_DERATE_HALF;
          else if (temp_band_code >= cgr_pkg::BAND_PLUS_10)
            derate_reg <= cgr_pkg::CGR_DERATE_FULL;
        cgr_pkg::CGR_DERATE_HALF:
          if (temp_band_code >= cgr_pkg::BAND_ZERO_C)
            derate_reg <= cgr_pkg::CGR_DERATE_FULL;
          else if (temp_band_code >= cgr_pkg::BAND_MINUS_20)
            derate_reg <= cgr_pkg::CGR_DERATE_3Q;
        default:
          derate_reg <= cgr_pkg::CGR_DERATE_FULL;
      endcase
    end
  end

  always_comb
  begin
    full_ref = (learned_capacity != cgr_pkg::BYTE_ZERO)
             ? {learned_capacity, 8'h00} : {programmed_full_capacity, 8'h00};
    case (derate_reg)
      cgr_pkg::CGR_DERATE_3Q:   scaled = 20'((24'({charge_count, 4'h0}) * 24'h3) >> 2);
      cgr_pkg::CGR_DERATE_HALF: scaled = 20'({charge_count, 4'h0}) >> 1;
      default:                  scaled = 20'({charge_count, 4'h0});
    endcase
    if (full_ref == 16'h0000)
      sixteenths = '0;
    else if (scaled / 20'(full_ref) > 20'(cgr_pkg::SIXTEENTHS_MAX))
      sixteenths = cgr_pkg::SIXTEENTHS_MAX;
    else
      sixteenths = 5'(scaled / 20'(full_ref));
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_data  <= cgr_pkg::BYTE_ZERO;
      rd_valid <= 1'b0;
    end
    else if (clk_en)
    begin
      rd_valid <= host_req.valid && !host_req.write;
      if (host_req.valid && !host_req.write)
      begin
        case (host_req.addr)
          cgr_pkg::ADDR_PRIMARY:  rd_data <= 8'(capacity_doubt_flag) << cgr_pkg::PRI_DOUBT_BIT;
          cgr_pkg::ADDR_TMPGAUGE: rd_data <= {band_reg, sixteenths[3:0]};
          cgr_pkg::ADDR_CHG_HI:   rd_data <= charge_count_high;
          cgr_pkg::ADDR_PACK_ID:  rd_data <= pack_identity_reg;
          cgr_pkg::ADDR_LEARNED:  rd_data <= learned_capacity;
          cgr_pkg::ADDR_SEC_FLG:  rd_data <= {fast_rate_flag, discharge_regime_code,
                                              3'h0, overload_flag};
          cgr_pkg::ADDR_PULLDN:   rd_data <= {2'h0, pulldown_bits_reg};
          cgr_pkg::ADDR_PULLUP:   rd_data <= {2'h0, pullup_bits_reg};
          cgr_pkg::ADDR_RECHG:    rd_data <= recharge_count_reg;
          cgr_pkg::ADDR_CHG_LO:   rd_data <= charge_count_low;
          default:                rd_data <= cgr_pkg::BYTE_ZERO;
        endcase
      end
    end
  end

endmodule

//--- dv/cgr_register_bank_properties.sv
// Purpose: port-level checks for the charge gauge register bank
// Assumes: one clock, asynchronous active-low reset
// Notes:   release and window counts follow the bound parameters
`timescale 1ns/1ps
module cgr_register_bank_properties #(
  parameter int OVERLOAD_FLAG_RELEASE_CYCLES = 20,
  parameter int FAST_WINDOW_CYCLES  = 50
) (
  // clock and reset
  input wire logic                 clk,
  input wire logic                 rst_n,
  input wire logic                 clk_en,
  // host side
  input wire cgr_pkg::cgr_req_t    host_req,
  input wire logic [7:0]           rd_data,
  input wire logic                 rd_valid,
  // events and status
  input wire cgr_pkg::cgr_events_t meas_ev,
  input wire logic                 capacity_doubt_flag,
  input wire logic                 fast_rate_flag,
  input wire logic                 edv_sampling_en
);
  localparam int QUIET_LIM = OVERLOAD_FLAG_RELEASE_CYCLES + 3;
  localparam int FAST_LIM  = 2 * FAST_WINDOW_CYCLES + 3;
  int   quiet_cnt;
  int   idle_cnt;
  logic rd_req;
  assign rd_req = clk_en && host_req.valid && !host_req.write;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // ----------------------------------------------------------------
  // cycles since overload, cycles since charge activity
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      quiet_cnt <= QUIET_LIM;
    else if (meas_ev.sense_below_250)
      quiet_cnt <= 0;
    else if (quiet_cnt < QUIET_LIM)
      quiet_cnt <= quiet_cnt + 1;
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      idle_cnt <= 0;
    else if (meas_ev.charge_tick || meas_ev.charge_begin)
      idle_cnt <= 0;
    else if (idle_cnt < FAST_LIM)
      idle_cnt <= idle_cnt + 1;
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_read_answer: assert property (rd_req |=> rd_valid)
    else $error("read not answered next cycle");
  a_no_stray_valid: assert property (clk_en && !rd_req |=> !rd_valid)
    else $error("read valid without a read");
  a_rd_data_hold: assert property (!rd_valid |-> $stable(rd_data))
    else $error("read data moved without a read");
  a_fast_on_begin: assert property (clk_en && meas_ev.charge_begin |=> fast_rate_flag)
    else $error("fast flag not set at charge start");
  a_fast_rise_cause: assert property ($rose(fast_rate_flag) |-> $past(meas_ev.charge_begin))
    else $error("fast flag rose without charge start");
  a_fast_expires: assert property (idle_cnt == FAST_LIM |-> !fast_rate_flag)
    else $error("fast flag held with no charge counts");
  a_edv_held: assert property (quiet_cnt < OVERLOAD_FLAG_RELEASE_CYCLES - 2 |-> !edv_sampling_en)
    else $error("sampling enabled during overload hold");
  a_edv_resumes: assert property (quiet_cnt == QUIET_LIM |-> edv_sampling_en)
    else $error("sampling not resumed after overload");
  a_doubt_at_reset: assert property ($rose(rst_n) |-> capacity_doubt_flag)
    else $error("doubt flag low after reset");
  a_doubt_cause: assert property (
    clk_en && !capacity_doubt_flag && !meas_ev.valid_charge |=> !capacity_doubt_flag)
    else $error("doubt flag set without a charge");
endmodule
bind cgr_register_bank cgr_register_bank_properties #(
  .OVERLOAD_FLAG_RELEASE_CYCLES(OVERLOAD_FLAG_RELEASE_CYCLES),
  .FAST_WINDOW_CYCLES (FAST_WINDOW_CYCLES)
) u_props (
  .clk                (clk),
  .rst_n              (rst_n),
  .clk_en             (clk_en),
  .host_req           (host_req),
  .rd_data            (rd_data),
  .rd_valid           (rd_valid),
  .meas_ev            (meas_ev),
  .capacity_doubt_flag(capacity_doubt_flag),
  .fast_rate_flag     (fast_rate_flag),
  .edv_sampling_en    (edv_sampling_en)
);

//--- dv/cgr_host_model.sv
// Purpose: host processor issuing decoded serial commands
// Assumes: framer already split command byte into write flag and address
// Notes:   idle fields show the inverse of the last command
`timescale 1ns/1ps
module cgr_host_model (
  // clock
  input wire logic          clk,
  // command port
  output cgr_pkg::cgr_req_t host_req,
  input wire logic [7:0]    rd_data,
  input wire logic          rd_valid
);
  initial host_req = '0;
  task automatic send(input logic wr, input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    host_req <= '{valid: 1'b1, write: wr, addr: a, data: d};
    @(posedge clk);
    host_req <= '{valid: 1'b0, write: ~wr, addr: ~a, data: ~d};
  endtask
  // callers keep charge count writes at or below the learned capacity
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    send(1'b1, a, d);
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    d = 8'hxx;
    send(1'b0, a, 8'h00);
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clk);
      if (rd_valid === 1'b1)
      begin
        d = rd_data;
        break;
      end
    end
  endtask
endmodule

//--- dv/cgr_register_bank_tb.sv
// Purpose: directed register and event tests of the register bank
// Assumes: short overload and fast-rate counts set by parameter
// Notes:   full capacity pin value is 50h throughout
`timescale 1ns/1ps
module cgr_register_bank_tb;
  localparam int         REL     = 20;
  localparam int         FW      = 50;
  localparam logic [6:0] E_TICK  = 7'h40;
  localparam logic [6:0] E_DIS   = 7'h20;
  localparam logic [6:0] E_VC    = 7'h10;
  localparam logic [6:0] E_EMPTY = 7'h08;
  localparam logic [6:0] E_BEGIN = 7'h04;
  logic                 clk = 1'b0;
  logic                 rst_n = 1'b0;
  cgr_pkg::cgr_req_t    host_req;
  logic [7:0]           rd_data;
  logic                 rd_valid;
  cgr_pkg::cgr_events_t mev = '0;
  logic [3:0]           band = 4'h6;
  logic                 pin6 = 1'b1;
  logic [5:0]           pdn = 6'h00;
  logic [5:0]           pup = 6'h00;
  logic [15:0]          sdc = 16'h0000;
  logic                 ce = 1'b1;
  logic                 doubt;
  logic                 fast;
  logic                 edv;
  logic [7:0]           v;
  int                   error_cnt = 0;
  int                   checked = 0;
  int                   cycles = 0;
  logic [3:0]           bands [5] = '{4'hC, 4'h3, 4'h4, 4'h5, 4'h1};
  logic [3:0]           gauges [5] = '{4'h8, 4'h6, 4'h6, 4'h8, 4'h4};
  always #2.5 clk = ~clk;
  cgr_register_bank #(.OVERLOAD_FLAG_RELEASE_CYCLES(REL), .FAST_WINDOW_CYCLES(FW)) dut (
    .clk                     (clk),
    .rst_n                   (rst_n),
    .clk_en                  (ce),
    .host_req                (host_req),
    .rd_data                 (rd_data),
    .rd_valid                (rd_valid),
    .meas_ev                 (mev),
    .temp_band_code          (band),
    .self_disch_count        (sdc),
    .programmed_full_capacity(8'h50),
    .sixth_program_pin       (pin6),
    .segment_pulldown        (pdn),
    .segment_pullup          (pup),
    .capacity_doubt_flag     (doubt),
    .fast_rate_flag          (fast),
    .edv_sampling_en         (edv)
  );
  cgr_host_model host (.clk(clk), .host_req(host_req), .rd_data(rd_data), .rd_valid(rd_valid));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [6:0] a, input logic [7:0] exp);
    host.rd(a, v);
    check(v, exp);
  endtask
  task automatic pulse(input logic [6:0] m);
    @(posedge clk);
    mev <= cgr_pkg::cgr_events_t'(mev | m);
    @(posedge clk);
    mev <= cgr_pkg::cgr_events_t'(mev & ~m);
  endtask
  task automatic do_reset(input logic p6);
    @(posedge clk);
    rst_n <= 1'b0;
    pin6 <= p6;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      error_cnt++;
      tally_and_finish();
    end
  end
  initial
  begin
    do_reset(1'b1);
    rchk(cgr_pkg::ADDR_CHG_HI, 8'h50);
    rchk(cgr_pkg::ADDR_CHG_LO, 8'h00);
    rchk(cgr_pkg::ADDR_LEARNED, 8'h50);
    rchk(cgr_pkg::ADDR_RECHG, 8'h00);
    rchk(cgr_pkg::ADDR_PRIMARY, 8'h10);
    pdn <= 6'h09;
    pup <= 6'h24;
    host.wr(cgr_pkg::ADDR_PACK_ID, 8'hA5);
    host.wr(cgr_pkg::ADDR_PULLDN, 8'hFF);
    host.wr(7'h40, 8'h5A);
    rchk(cgr_pkg::ADDR_PULLDN, 8'h09);
    rchk(cgr_pkg::ADDR_PULLUP, 8'h24);
    rchk(cgr_pkg::ADDR_PACK_ID, 8'hA5);
    rchk(7'h40, 8'h00);
    // half charge seen through each derating band
    host.wr(cgr_pkg::ADDR_CHG_HI, 8'h28);
    for (int i = 0; i < 5; i++)
    begin
      band <= bands[i];
      rchk(cgr_pkg::ADDR_TMPGAUGE, {bands[i], gauges[i]});
    end
    band <= 4'h6;
    pulse(E_DIS);
    pulse(E_VC);
    rchk(cgr_pkg::ADDR_CHG_LO, 8'h00);
    rchk(cgr_pkg::ADDR_RECHG, 8'h01);
    host.wr(cgr_pkg::ADDR_CHG_HI, 8'h50);
    pulse(E_VC);
    pulse(E_VC);
    rchk(cgr_pkg::ADDR_RECHG, 8'h02);
    host.wr(cgr_pkg::ADDR_CHG_HI, 8'h10);
    pulse(E_VC);
    rchk(cgr_pkg::ADDR_RECHG, 8'h03);
    // full-to-empty discharge, warm: learned capacity updates
    host.wr(cgr_pkg::ADDR_CHG_HI, 8'h50);
    pulse(E_DIS);
    host.wr(cgr_pkg::ADDR_CHG_HI, 8'h10);
    pulse(E_EMPTY);
    rchk(cgr_pkg::ADDR_LEARNED, 8'h40);
    rchk(cgr_pkg::ADDR_RECHG, 8'h00);
    rchk(cgr_pkg::ADDR_PRIMARY, 8'h00);
    // same discharge when cold: no update
    band <= 4'h3;
    host.wr(cgr_pkg::ADDR_CHG_HI, 8'h40);
    pulse(E_DIS);
    host.wr(cgr_pkg::ADDR_CHG_HI, 8'h10);
    pulse(E_EMPTY);
    rchk(cgr_pkg::ADDR_LEARNED, 8'h40);
    band <= 4'h6;
    // warm discharge with a full self-discharge count: no update
    sdc <= 16'h1000;
    host.wr(cgr_pkg::ADDR_CHG_HI, 8'h40);
    pulse(E_DIS);
    host.wr(cgr_pkg::ADDR_CHG_HI, 8'h10);
    pulse(E_EMPTY);
    rchk(cgr_pkg::ADDR_LEARNED, 8'h40);
    sdc <= 16'h0000;
    repeat (63) pulse(E_VC);
    @(posedge clk);
    check({7'h00, doubt}, 8'h00);
    pulse(E_VC);
    rchk(cgr_pkg::ADDR_RECHG, 8'h40);
    ce <= 1'b0;
    pulse(E_VC);
    ce <= 1'b1;
    rchk(cgr_pkg::ADDR_RECHG, 8'h40);
    rchk(cgr_pkg::ADDR_PRIMARY, 8'h10);
    repeat (192) pulse(E_VC);
    rchk(cgr_pkg::ADDR_RECHG, 8'hFF);
    // fast rate flag set, expires, then held by steady counts
    pulse(E_BEGIN);
    rchk(cgr_pkg::ADDR_SEC_FLG, 8'h80);
    repeat (3 * FW) @(posedge clk);
    rchk(cgr_pkg::ADDR_SEC_FLG, 8'h00);
    pulse(E_BEGIN);
    repeat (12)
    begin
      pulse(E_TICK);
      repeat (8) @(posedge clk);
    end
    check({7'h00, fast}, 8'h01);
    repeat (3 * FW) @(posedge clk);
    mev.sense_below_150 <= 1'b1;
    rchk(cgr_pkg::ADDR_SEC_FLG, 8'h10);
    mev.sense_below_250 <= 1'b1;
    rchk(cgr_pkg::ADDR_SEC_FLG, 8'h11);
    check({7'h00, edv}, 8'h00);
    mev.sense_below_250 <= 1'b0;
    repeat (REL / 2) @(posedge clk);
    rchk(cgr_pkg::ADDR_SEC_FLG, 8'h11);
    repeat (REL) @(posedge clk);
    rchk(cgr_pkg::ADDR_SEC_FLG, 8'h10);
    check({7'h00, edv}, 8'h01);
    mev.sense_below_150 <= 1'b0;
    rchk(cgr_pkg::ADDR_SEC_FLG, 8'h00);
    do_reset(1'b0);
    rchk(cgr_pkg::ADDR_CHG_HI, 8'h00);
    rchk(cgr_pkg::ADDR_LEARNED, 8'h50);
    rchk(cgr_pkg::ADDR_PRIMARY, 8'h10);
    tally_and_finish();
  end
endmodule
